/* File: five_stage_preset_pkg.sv */
// Constants and types shared by the five-stage preset shifter
package five_stage_preset_pkg;

	localparam int          STAGE_COUNT  = 5;
	localparam logic [4:0]  STAGES_RESET = 5'h00;
	localparam logic [4:0]  STAGES_CLEAR = 5'h00;

	// Stage positions in the stage vector, first stage at bit zero
	localparam int FIRST_IDX  = 0;
	localparam int SECOND_IDX = 1;
	localparam int THIRD_IDX  = 2;
	localparam int FOURTH_IDX = 3;
	localparam int FIFTH_IDX  = 4;

	// Layout of the synchronised pin vector
	localparam int PIN_COUNT     = 9;
	localparam int PIN_SERIAL    = 0;
	localparam int PIN_SET_LO    = 1;
	localparam int PIN_SET_HI    = 5;
	localparam int PIN_SET_EN    = 6;
	localparam int PIN_CLEAR_N   = 7;
	localparam int PIN_SHIFT_CLK = 8;
	// Shift clock bit resets high, so a clock already high at release is no edge
	localparam logic [8:0] PINS_RESET = 9'h100;

	// Shift clock edge detector, one-hot
	typedef enum logic [2:0] {
		EDGE_WAIT_LOW = 3'h1,
		EDGE_LOW      = 3'h2,
		EDGE_HIGH     = 3'h4
	} edge_state_t;

endpackage

/* File: pin_sync2.sv */
// Two flip-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/10ps
module pin_sync2 #(
	parameter int         WIDTH    = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb begin
		meta_d = d;
		sync_d = meta_q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign q = sync_q;

endmodule

/* File: five_stage_preset_shifter.sv */
// Five-stage serial-in parallel-out shift register with per-stage preset
`timescale 1ns/10ps

module five_stage_preset_shifter
(
	input  wire logic                                          MCLK,
	input  wire logic                                          RESETN,
	input  wire logic                                          SHIFT_CLK,
	input  wire logic                                          CLEAR_N,
	input  wire logic                                          SET_ENABLE,
	input  wire logic [five_stage_preset_pkg::STAGE_COUNT-1:0] SET_LINES,
	input  wire logic                                          SERIAL_IN,
	output logic                                               FIRST_STAGE_OUT,
	output logic                                               SECOND_STAGE_OUT,
	output logic                                               THIRD_STAGE_OUT,
	output logic                                               FOURTH_STAGE_OUT,
	output logic                                               FIFTH_STAGE_OUT
);

	import five_stage_preset_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [PIN_COUNT-1:0]   pins_raw;
	logic [PIN_COUNT-1:0]   pins_sync;
	logic                   shift_clk_s;
	logic                   clear_n_s;
	logic                   set_en_s;
	logic [STAGE_COUNT-1:0] set_lines_s;
	logic                   serial_s;

	always_comb begin
		pins_raw                           = PINS_RESET;
		pins_raw[PIN_SERIAL]               = SERIAL_IN;
		pins_raw[PIN_SET_HI:PIN_SET_LO]    = SET_LINES;
		pins_raw[PIN_SET_EN]               = SET_ENABLE;
		pins_raw[PIN_CLEAR_N]              = CLEAR_N;
		pins_raw[PIN_SHIFT_CLK]            = SHIFT_CLK;
	end

	pin_sync2 #(
		.WIDTH   (PIN_COUNT),
		.RST_VAL (PINS_RESET)
	) pin_sync2_inst (
		.clk   (MCLK),
		.rst_n (RESETN),
		.d     (pins_raw),
		.q     (pins_sync)
	);

	assign serial_s    = pins_sync[PIN_SERIAL];
	assign set_lines_s = pins_sync[PIN_SET_HI:PIN_SET_LO];
	assign set_en_s    = pins_sync[PIN_SET_EN];
	assign clear_n_s   = pins_sync[PIN_CLEAR_N];
	assign shift_clk_s = pins_sync[PIN_SHIFT_CLK];

	////////////////////////////////////////////////////////////////////////
	// Shift clock rising edge detection

	edge_state_t edge_q;
	edge_state_t edge_d;
	logic        shift_rise;

	// A clock already high at reset release is not taken as an edge
	always_comb begin
		edge_d     = edge_q;
		shift_rise = 1'b0;
		case (edge_q)
			EDGE_WAIT_LOW: begin
				if (!shift_clk_s) begin
					edge_d = EDGE_LOW;
				end
			end
			EDGE_LOW: begin
				if (shift_clk_s) begin
					edge_d     = EDGE_HIGH;
					shift_rise = 1'b1;
				end
			end
			EDGE_HIGH: begin
				if (!shift_clk_s) begin
					edge_d = EDGE_LOW;
				end
			end
			default: begin
				edge_d = EDGE_WAIT_LOW;
			end
		endcase
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			edge_q <= EDGE_WAIT_LOW;
		end else begin
			edge_q <= edge_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Stage chain

	// One register per stage, first stage nearest the serial input
	logic                   first_q;
	logic                   first_d;
	logic                   second_q;
	logic                   second_d;
	logic                   third_q;
	logic                   third_d;
	logic                   fourth_q;
	logic                   fourth_d;
	logic                   fifth_q;
	logic                   fifth_d;
	logic [STAGE_COUNT-1:0] set_hits;
	logic                   shift_go;

	// Preset beats clear, clear beats shift, otherwise hold
	function automatic logic stage_next(
		input logic cur,
		input logic prev,
		input logic shift,
		input logic clr_n,
		input logic clr_val,
		input logic set_hit
	);
		logic v;
		v = cur;
		if (shift) begin
			v = prev;
		end
		if (!clr_n) begin
			v = clr_val;
		end
		if (set_hit) begin
			v = 1'b1;
		end
		return v;
	endfunction

	// Set-enable high freezes shifting, so presets never race a shift
	always_comb begin
		set_hits = set_lines_s & {STAGE_COUNT{set_en_s}};
		shift_go = shift_rise & ~set_en_s;
		first_d = stage_next(
			first_q,
			serial_s,
			shift_go,
			clear_n_s,
			STAGES_CLEAR[FIRST_IDX],
			set_hits[FIRST_IDX]
		);

		second_d = stage_next(
			second_q,
			first_q,
			shift_go,
			clear_n_s,
			STAGES_CLEAR[SECOND_IDX],
			set_hits[SECOND_IDX]
		);

		third_d = stage_next(
			third_q,
			second_q,
			shift_go,
			clear_n_s,
			STAGES_CLEAR[THIRD_IDX],
			set_hits[THIRD_IDX]
		);

		fourth_d = stage_next(
			fourth_q,
			third_q,
			shift_go,
			clear_n_s,
			STAGES_CLEAR[FOURTH_IDX],
			set_hits[FOURTH_IDX]
		);

		// Old fifth stage value drops off the end
		fifth_d = stage_next(
			fifth_q,
			fourth_q,
			shift_go,
			clear_n_s,
			STAGES_CLEAR[FIFTH_IDX],
			set_hits[FIFTH_IDX]
		);
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			first_q  <= STAGES_RESET[FIRST_IDX];
			second_q <= STAGES_RESET[SECOND_IDX];
			third_q  <= STAGES_RESET[THIRD_IDX];
			fourth_q <= STAGES_RESET[FOURTH_IDX];
			fifth_q  <= STAGES_RESET[FIFTH_IDX];
		end else begin
			first_q  <= first_d;
			second_q <= second_d;
			third_q  <= third_d;
			fourth_q <= fourth_d;
			fifth_q  <= fifth_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Parallel outputs

	assign FIRST_STAGE_OUT  = first_q;
	assign SECOND_STAGE_OUT = second_q;
	assign THIRD_STAGE_OUT  = third_q;
	assign FOURTH_STAGE_OUT = fourth_q;
	assign FIFTH_STAGE_OUT  = fifth_q;

endmodule

/* File: shift_pin_driver.sv */
// Outside logic making shift clock pulses and serial data
`timescale 1ns/10ps
module shift_pin_driver (
	input  wire logic MCLK,
	input  wire logic go,
	input  wire logic bit_in,
	output logic      shift_clk,
	output logic      serial
);
	logic [2:0] ph;
	initial {ph, shift_clk, serial} = 5'h00;
	always @(posedge MCLK) begin
		// Two cycles high, at least four low
		shift_clk <= (ph == 3'h1) || (ph == 3'h2);
		if (go || ph != 3'h0)
			ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
		if (ph == 3'h0)
			serial <= bit_in;
	end
endmodule

/* File: five_stage_preset_shifter_checker.sv */
// Checker for the five-stage preset shifter
`timescale 1ns/10ps
module five_stage_checker (
	input wire logic       MCLK, RESETN, SHIFT_CLK, CLEAR_N, SET_ENABLE, SERIAL_IN,
	input wire logic [4:0] SET_LINES,
	input wire logic       FIRST_STAGE_OUT, SECOND_STAGE_OUT, THIRD_STAGE_OUT,
	input wire logic       FOURTH_STAGE_OUT, FIFTH_STAGE_OUT
);
	wire [4:0] st = {FIFTH_STAGE_OUT, FOURTH_STAGE_OUT, THIRD_STAGE_OUT,
		SECOND_STAGE_OUT, FIRST_STAGE_OUT};
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	// Pins act three edges later
	sequence s_calm;
		$past(CLEAR_N, 3) && !($past(SHIFT_CLK, 3) && !$past(SHIFT_CLK, 4));
	endsequence
	sequence s_shift;
		$past(CLEAR_N, 3) && !$past(SET_ENABLE, 3) && $past(SHIFT_CLK, 3) && !$past(SHIFT_CLK, 4);
	endsequence
	sequence s_rise;
		$past(SHIFT_CLK, 3) && !$past(SHIFT_CLK, 4);
	endsequence
	a_clear_low: assert property (
		!$past(CLEAR_N, 3) && !$past(SET_ENABLE, 3) |-> st == 5'h00) else $error("clear");
	a_set_high: assert property (
		$past(SET_ENABLE, 3) |-> (st & $past(SET_LINES, 3)) == $past(SET_LINES, 3)) else $error("set");
	a_set_rest: assert property (
		s_calm ##0 $past(SET_ENABLE, 3) |-> ((st ^ $past(st)) & ~$past(SET_LINES, 3)) == 5'h00)
		else $error("set rest");
	a_hold_idle: assert property (
		s_calm ##0 !($past(SET_ENABLE, 3) && |$past(SET_LINES, 3)) |-> $stable(st)) else $error("hold");
	a_shift_all: assert property (
		s_shift |-> st[4:1] == $past(st[3:0])) else $error("shift");
	a_shift_high: assert property (
		s_shift ##0 $past(SERIAL_IN, 3) |-> FIRST_STAGE_OUT) else $error("shift high");
	a_shift_low: assert property (
		s_shift ##0 !$past(SERIAL_IN, 3) |-> !FIRST_STAGE_OUT) else $error("shift low");
	a_last_drop: assert property (
		s_shift |-> FIFTH_STAGE_OUT == $past(FOURTH_STAGE_OUT)) else $error("fifth");
	a_shift_blocked: assert property (
		s_rise ##0 ($past(CLEAR_N, 3) && $past(SET_ENABLE, 3) && $past(SET_LINES, 3) == 5'h00)
		|-> $stable(st)) else $error("set enable must block shift");
endmodule
bind five_stage_preset_shifter five_stage_checker five_stage_checker_inst (.MCLK(MCLK),
	.RESETN(RESETN), .SHIFT_CLK(SHIFT_CLK), .CLEAR_N(CLEAR_N), .SET_ENABLE(SET_ENABLE),
	.SERIAL_IN(SERIAL_IN), .SET_LINES(SET_LINES), .FIRST_STAGE_OUT(FIRST_STAGE_OUT),
	.SECOND_STAGE_OUT(SECOND_STAGE_OUT), .THIRD_STAGE_OUT(THIRD_STAGE_OUT),
	.FOURTH_STAGE_OUT(FOURTH_STAGE_OUT), .FIFTH_STAGE_OUT(FIFTH_STAGE_OUT));

/* File: tb_five_stage_preset_shifter.sv */
// Self-checking bench for the five-stage preset shifter
`timescale 1ns/10ps
module tb_five_stage_preset_shifter;
	logic       mclk, resetn, clear_n, set_en, go, bit_in, shift_clk, serial;
	logic [4:0] set_lines, e, w;
	wire  [4:0] q;
	logic [4:0] exp_q [$];
	int         err_total, samples_checked;
	event       chk;
	always #5 mclk = ~mclk;
	shift_pin_driver shift_pin_driver_inst (.MCLK(mclk), .go(go), .bit_in(bit_in),
		.shift_clk(shift_clk), .serial(serial));
	five_stage_preset_shifter five_stage_preset_shifter_inst (.MCLK(mclk), .RESETN(resetn),
		.SHIFT_CLK(shift_clk), .CLEAR_N(clear_n), .SET_ENABLE(set_en), .SET_LINES(set_lines),
		.SERIAL_IN(serial), .FIRST_STAGE_OUT(q[0]), .SECOND_STAGE_OUT(q[1]),
		.THIRD_STAGE_OUT(q[2]), .FOURTH_STAGE_OUT(q[3]), .FIFTH_STAGE_OUT(q[4]));
	task automatic shift_bit(input logic b);
		bit_in = b;
		go = 1'h1;
		@(negedge mclk);
		go = 1'h0;
	endtask
	task automatic step(input logic [4:0] v);
		repeat (8) @(negedge mclk);
		exp_q.push_back(v);
		-> chk;
	endtask
	always @(chk) begin
		samples_checked++;
		w = exp_q.pop_front();
		if (q !== w) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, q, w);
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{mclk, resetn, set_en, go, bit_in, set_lines, e} = 15'h0000;
		clear_n = 1'h1;
		{err_total, samples_checked} = 0;
		void'($urandom(32'hFF38689B));
		repeat (4) @(negedge mclk);
		resetn = 1'h1;
		step(e);
		for (int i = 0; i < 8; i++) begin
			shift_bit(1'($urandom));
			e = {e[3:0], bit_in};
			step(e);
		end
		set_lines = 5'($urandom) | 5'h01;
		set_en = 1'h1;
		e = e | set_lines;
		step(e);
		set_lines = 5'h00;
		step(e);
		shift_bit(~e[0]);
		step(e);
		set_en = 1'h0;
		bit_in = ~bit_in;
		step(e);
		clear_n = 1'h0;
		step(5'h00);
		clear_n = 1'h1;
		@(negedge mclk);
		complete_run;
	end
endmodule
